// file: core/wsw_pkg.sv
// Constants, types and register map for the watchdog and sleep controller
package wsw_pkg;
   // Register offsets
   localparam logic [13:0] OFS_STATUS = 14'h0003;
   localparam logic [13:0] OFS_OPTION = 14'h0081;
   localparam logic [13:0] OFS_ID_FIRST = 14'h2000;
   localparam logic [13:0] OFS_ID_LAST = 14'h2003;
   localparam logic [13:0] OFS_CONFIG = 14'h2007;
   // Status bit positions
   localparam int STATUS_PD_BIT = 3;
   localparam int STATUS_TO_BIT = 4;
   // Option bit positions
   localparam int OPT_PSA_BIT = 3;
   localparam int OPT_PS_LSB = 0;
   localparam logic [7:0] OPTION_RESET = 8'hff;
   // Configuration word bit positions
   localparam int CFG_OSC_LSB = 0;
   localparam int CFG_WATCHDOG_ENABLE_FUSE_BIT = 2;
   localparam int CFG_CP0_BIT = 4;
   localparam int CFG_CP1_BIT = 5;
   localparam logic [1:0] OSC_MODE_RC = 2'h3;
   localparam logic [1:0] CP_UNPROGRAMMED = 2'h3;
   // Watchdog timing: base period measured on the watchdog RC oscillator
   localparam int WDT_BASE_US = 18000;
   localparam int WOSC_KHZ = 100;
   localparam int WDT_BASE_TICKS = WDT_BASE_US * WOSC_KHZ / 1000;
   // Oscillator start-up delay, one oscillator period per core clock
   localparam int SYS_CLK_MHZ = 25;
   localparam int TOSC_NS = 40;
   localparam int OST_TOSC = 1024;
   localparam int OST_CYCLES = OST_TOSC * TOSC_NS * SYS_CLK_MHZ / 1000;
   localparam int SYNC_STAGES = 3;
   localparam int IRQ_W = 8;
   // Sleep controller states
   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_OST, ST_RESUME} wsw_state_t;
   // Instruction events from the core
   typedef struct packed {
      logic watchdog_clear_instr;
      logic sleep;
   } wsw_instr_t;
   // Interrupt view from the interrupt controller
   typedef struct packed {
      logic [IRQ_W-1:0] flags;
      logic [IRQ_W-1:0] enables;
      logic [IRQ_W-1:0] sleep_capable;
      logic global_irq_enable;
   } wsw_irq_t;
endpackage

// file: core/wsw_core.sv
// Watchdog timer with prescaler, sleep control, status flags and fuse gating
`timescale 1ns/1ps
// Functional notes
// - Watchdog counts ticks of its own RC oscillator, also during sleep.
// - Watchdog expiry while running gives a full device reset.
// - Watchdog expiry while asleep wakes the device and resumes execution.
// - Cleared watchdog enable fuse keeps the watchdog permanently off.
// - Base period 18 ms; shared prescaler extends it up to 128 periods.
// - Clear and sleep instructions zero the counter and assigned prescaler.
// - In sleep an expiry never resets, it only wakes.
// - Every expiry clears the timeout status flag.
// - Clear instruction zeroes prescaler count, assignment stays unchanged.
// - Sleep clears watchdog, clears powerdown flag, sets timeout flag, stops oscillator.
// - I/O pins hold their previous state throughout sleep.
// - Sleep ends on master clear (reset), watchdog or enabled interrupt (continue).
// - Powerdown flag set at power-up, cleared by each executed sleep instruction.
// - Interrupt wakes only when its enable is set, whatever the global enable.
// - After interrupt wake run the prefetched instruction, then vector if global enable set.
// - Sleep with enabled interrupt already pending acts as a no-op.
// - Interrupt during or after sleep: finish sleep effects, then wake at once.
// - Only peripherals able to run without core clocks may wake from sleep.
// - Crystal modes wait 1024 oscillator periods on wake; RC mode does not.
// - Program readout allowed only while code protection is unprogrammed.
// - ID words 2000h-2003h reachable only in program/verify mode.
module wsw_core #(
   parameter int WDT_TICKS = wsw_pkg::WDT_BASE_TICKS
) (
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic CLK_EN,
   input wire logic [13:0] BUS_ADDR,
   input wire logic [7:0] BUS_WDATA,
   input wire logic BUS_WR,
   input wire logic BUS_RD,
   output logic [7:0] BUS_RDATA,
   input wire wsw_pkg::wsw_instr_t INSTR,
   input wire wsw_pkg::wsw_irq_t IRQ,
   input wire logic [7:0] CONFIG_WORD,
   input wire logic PROG_MODE,
   input wire logic MASTER_CLEAR_INPUT_N,
   input wire logic WDT_OSC,
   output logic DEV_RESET,
   output logic CORE_RUN,
   output logic OSC_DRV_EN,
   output logic IO_HOLD,
   output logic WAKE,
   output logic WAKE_VECTOR,
   output logic PROG_READ_EN,
   output logic TIMEOUT_FLAG,
   output logic POWERDOWN_FLAG
);
   import wsw_pkg::*;

   wsw_state_t state_r, state_nxt;
   logic [SYNC_STAGES-1:0] sync_r [2];
   logic master_clear_input_lvl_r, osc_lvl_r;
   logic [15:0] wdt_cnt_r;
   logic [7:0] pre_cnt_r;
   logic [10:0] ost_cnt_r;
   logic [7:0] option_r;
   logic [7:0] id_mem_r [4];
   logic [7:0] rdata_r;
   logic to_r, pd_r, dev_rst_r, wake_r, vector_r, irq_wake_r;
   logic wdt_en, osc_tick, base_last, wdt_exp, wdt_clear, pre_clear;
   logic irq_pending, irq_sleep_wake, sleep_go, sleep_nop, master_clear_input_low, crystal_mode;
   logic [7:0] ratio_last;
   logic id_hit;

   // Pin synchronisers: watchdog oscillator and master clear
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         sync_r[0] <= '0;
         sync_r[1] <= {SYNC_STAGES{1'b1}};
      end else if (CLK_EN) begin
         sync_r[0] <= {sync_r[0][SYNC_STAGES-2:0], WDT_OSC};
         sync_r[1] <= {sync_r[1][SYNC_STAGES-2:0], MASTER_CLEAR_INPUT_N};
      end
   end

   // Filtered levels change only when the second and third stages agree
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         osc_lvl_r <= 1'b0;
         master_clear_input_lvl_r <= 1'b1;
      end else if (CLK_EN) begin
         if (sync_r[0][1] == sync_r[0][2]) begin
            osc_lvl_r <= sync_r[0][2];
         end
         if (sync_r[1][1] == sync_r[1][2]) begin
            master_clear_input_lvl_r <= sync_r[1][2];
         end
      end
   end

   // Tick on each rising oscillator edge, in the core domain
   assign osc_tick = CLK_EN && sync_r[0][2] && (sync_r[0][1] == sync_r[0][2]) && !osc_lvl_r;
   assign master_clear_input_low = !master_clear_input_lvl_r;

   // Fuse and option decode
   assign wdt_en = CONFIG_WORD[CFG_WATCHDOG_ENABLE_FUSE_BIT];
   assign crystal_mode = CONFIG_WORD[CFG_OSC_LSB +: 2] != OSC_MODE_RC;
   assign ratio_last = 8'((9'h001 << option_r[OPT_PS_LSB +: 3]) - 9'h001);
   assign base_last = wdt_cnt_r == 16'(WDT_TICKS - 1);

   // Expiry after the base period, times the ratio when assigned
   assign wdt_exp = wdt_en && osc_tick && base_last && !wdt_clear &&
                    (!option_r[OPT_PSA_BIT] || pre_cnt_r == ratio_last);

   // Interrupt qualification: own enable only, global enable ignored
   assign irq_pending = |(IRQ.flags & IRQ.enables);
   assign irq_sleep_wake = |(IRQ.flags & IRQ.enables & IRQ.sleep_capable);

   // Sleep instruction taken, or dropped as a no-op when a wake is pending
   assign sleep_go = CLK_EN && state_r == ST_RUN && INSTR.sleep && !irq_pending;
   assign sleep_nop = state_r == ST_RUN && INSTR.sleep && irq_pending;

   // Counter clears from the instruction stream
   assign wdt_clear = CLK_EN && state_r == ST_RUN && (INSTR.watchdog_clear_instr || sleep_go);
   assign pre_clear = wdt_clear && option_r[OPT_PSA_BIT];

   // Watchdog base counter on the RC oscillator ticks
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         wdt_cnt_r <= 16'h0000;
      end else if (CLK_EN) begin
         if (!wdt_en || wdt_clear || master_clear_input_low) begin
            wdt_cnt_r <= 16'h0000;
         end else if (osc_tick) begin
            wdt_cnt_r <= base_last ? 16'h0000 : wdt_cnt_r + 16'h0001;
         end
      end
   end

   // Prescaler count; assignment bit is never touched by a clear
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         pre_cnt_r <= 8'h00;
      end else if (CLK_EN) begin
         if (!wdt_en || pre_clear || wdt_exp || !option_r[OPT_PSA_BIT] || master_clear_input_low) begin
            pre_cnt_r <= 8'h00;
         end else if (osc_tick && base_last) begin
            pre_cnt_r <= pre_cnt_r + 8'h01;
         end
      end
   end

   // Sleep and wake sequencing
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN: begin
            if (sleep_go) begin
               state_nxt = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            // Wake sources; a pending interrupt wakes right after entry
            if (wdt_exp || irq_sleep_wake) begin
               state_nxt = crystal_mode ? ST_OST : ST_RESUME;
            end
         end
         ST_OST: begin
            if (ost_cnt_r == 11'(OST_CYCLES - 1)) begin
               state_nxt = ST_RESUME;
            end
         end
         ST_RESUME: begin
            state_nxt = ST_RUN;
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   // State register; master clear always ends sleep through a reset
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         state_r <= ST_RUN;
      end else if (CLK_EN) begin
         state_r <= master_clear_input_low ? ST_RUN : state_nxt;
      end
   end

   // Oscillator start-up counter
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         ost_cnt_r <= 11'h000;
      end else if (CLK_EN) begin
         ost_cnt_r <= (state_r == ST_OST) ? ost_cnt_r + 11'h001 : 11'h000;
      end
   end

   // Remember whether the wake came from an interrupt
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         irq_wake_r <= 1'b0;
      end else if (CLK_EN && state_r == ST_SLEEP && state_nxt != ST_SLEEP) begin
         irq_wake_r <= irq_sleep_wake && !wdt_exp;
      end
   end

   // Wake pulse and vector request; core runs the prefetched word first
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         wake_r <= 1'b0;
         vector_r <= 1'b0;
      end else if (CLK_EN) begin
         wake_r <= state_r == ST_RESUME && !master_clear_input_low;
         vector_r <= state_r == ST_RESUME && !master_clear_input_low && irq_wake_r && IRQ.global_irq_enable;
      end
   end

   // Device reset: master clear level, or one pulse on a running expiry
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         dev_rst_r <= 1'b0;
      end else if (CLK_EN) begin
         dev_rst_r <= master_clear_input_low || (wdt_exp && state_r != ST_SLEEP);
      end
   end

   // Timeout flag: set at power-up and by sleep, cleared by any expiry
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         to_r <= 1'b1;
      end else if (CLK_EN) begin
         if (wdt_exp) begin
            to_r <= 1'b0;
         end else if (sleep_go) begin
            to_r <= 1'b1;
         end
      end
   end

   // Powerdown flag: set at power-up, cleared by an executed sleep
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         pd_r <= 1'b1;
      end else if (CLK_EN && sleep_go) begin
         pd_r <= 1'b0;
      end
   end

   // Option register, written by software
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         option_r <= OPTION_RESET;
      end else if (CLK_EN && BUS_WR && BUS_ADDR == OFS_OPTION) begin
         option_r <= BUS_WDATA;
      end
   end

   // ID words, writable only in program/verify mode
   assign id_hit = BUS_ADDR >= OFS_ID_FIRST && BUS_ADDR <= OFS_ID_LAST;
   generate
      for (genvar g = 0; g < 4; g++) begin : g_id
         always_ff @(posedge SYS_CLK) begin
            if (!RESETN) begin
               id_mem_r[g] <= 8'h00;
            end else if (CLK_EN && BUS_WR && PROG_MODE && BUS_ADDR == OFS_ID_FIRST + 14'(g)) begin
               id_mem_r[g] <= BUS_WDATA;
            end
         end
      end
   endgenerate

   // Read data, valid the cycle after the strobe only
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         rdata_r <= 8'h00;
      end else if (CLK_EN) begin
         rdata_r <= 8'h00;
         if (BUS_RD) begin
            if (BUS_ADDR == OFS_OPTION) begin
               rdata_r <= option_r;
            end else if (BUS_ADDR == OFS_CONFIG) begin
               rdata_r <= CONFIG_WORD;
            end else if (BUS_ADDR == OFS_STATUS) begin
               rdata_r[STATUS_TO_BIT] <= to_r;
               rdata_r[STATUS_PD_BIT] <= pd_r;
            end else if (id_hit && PROG_MODE) begin
               rdata_r <= id_mem_r[BUS_ADDR[1:0]];
            end
         end
      end
   end

   // Outputs
   assign BUS_RDATA = rdata_r;
   assign DEV_RESET = dev_rst_r;
   assign CORE_RUN = state_r == ST_RUN;
   assign OSC_DRV_EN = state_r != ST_SLEEP;
   assign IO_HOLD = state_r != ST_RUN && state_r != ST_RESUME;
   assign WAKE = wake_r;
   assign WAKE_VECTOR = vector_r;
   assign PROG_READ_EN = PROG_MODE &&
      {CONFIG_WORD[CFG_CP1_BIT], CONFIG_WORD[CFG_CP0_BIT]} == CP_UNPROGRAMMED;
   assign TIMEOUT_FLAG = to_r;
   assign POWERDOWN_FLAG = pd_r;

   // Checks on the watchdog and sleep sequencing
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);

   a_wdt_fuse_off: assert property (!wdt_en && CLK_EN |=> wdt_cnt_r == 16'h0000)
      else $error("watchdog counts while fuse off");
   a_run_exp_reset: assert property (wdt_exp && state_r == ST_RUN |=> DEV_RESET)
      else $error("running expiry gave no reset");
   a_sleep_no_reset: assert property (wdt_exp && state_r == ST_SLEEP && !master_clear_input_low
      |=> !DEV_RESET && state_r != ST_SLEEP)
      else $error("sleep expiry reset or did not wake");
   a_exp_clears_to: assert property (wdt_exp |=> !TIMEOUT_FLAG)
      else $error("expiry left timeout flag set");
   a_sleep_entry: assert property (sleep_go && !master_clear_input_low |=> state_r == ST_SLEEP
      && !POWERDOWN_FLAG && TIMEOUT_FLAG && wdt_cnt_r == 16'h0000 && !OSC_DRV_EN)
      else $error("sleep entry side effects missing");
   a_sleep_nop: assert property (sleep_nop && CLK_EN && !master_clear_input_low && !wdt_exp
      |=> state_r == ST_RUN && $stable(POWERDOWN_FLAG) && $stable(TIMEOUT_FLAG))
      else $error("pending interrupt did not make sleep a no-op");
   a_clr_zeroes: assert property (wdt_clear && option_r[OPT_PSA_BIT] &&
      !(BUS_WR && BUS_ADDR == OFS_OPTION)
      |=> wdt_cnt_r == 16'h0000 && pre_cnt_r == 8'h00 && $stable(option_r[OPT_PSA_BIT]))
      else $error("clear left counts or changed assignment");
   a_ost_length: assert property (state_r == ST_OST && CLK_EN && !master_clear_input_low &&
      ost_cnt_r == 11'(OST_CYCLES - 1) |=> state_r == ST_RESUME ##1 WAKE)
      else $error("start-up delay length wrong");
   a_rc_no_delay: assert property (state_r == ST_SLEEP && state_nxt != ST_SLEEP &&
      CLK_EN && !master_clear_input_low && !crystal_mode |=> state_r == ST_RESUME)
      else $error("delay applied in RC mode");
   a_irq_wakes: assert property (state_r == ST_SLEEP && irq_sleep_wake &&
      CLK_EN && !master_clear_input_low |=> state_r != ST_SLEEP)
      else $error("enabled interrupt did not wake");
   a_id_locked: assert property (BUS_RD && CLK_EN && id_hit && !PROG_MODE
      |=> BUS_RDATA == 8'h00)
      else $error("ID word visible outside program mode");
   a_io_hold: assert property (state_r == ST_SLEEP |-> IO_HOLD && !CORE_RUN)
      else $error("pins not held in sleep");
   // Wake, reset, fuse and bus checks
   a_wake_pulse: assert property (WAKE && CLK_EN |=> !WAKE)
      else $error("wake pulse longer than one cycle");
   a_vector_gie: assert property (WAKE_VECTOR && $past(CLK_EN)
      |-> WAKE && $past(IRQ.global_irq_enable))
      else $error("vector request without global enable");
   a_master_clear_input_reset: assert property (master_clear_input_low && CLK_EN |=> DEV_RESET && CORE_RUN)
      else $error("master clear gave no reset");
   a_prog_read: assert property (PROG_READ_EN
      |-> PROG_MODE && CONFIG_WORD[CFG_CP1_BIT] && CONFIG_WORD[CFG_CP0_BIT])
      else $error("readout open under code protection");
   a_osc_runs: assert property (state_r == ST_SLEEP && osc_tick && !base_last &&
      wdt_en && !master_clear_input_low |=> wdt_cnt_r == $past(wdt_cnt_r) + 16'h0001)
      else $error("watchdog stopped counting in sleep");
   a_fuse_no_reset: assert property (!wdt_en && !master_clear_input_low && CLK_EN |=> !DEV_RESET)
      else $error("reset while watchdog fuse off");
   a_sleep_pre_clr: assert property (sleep_go && option_r[OPT_PSA_BIT]
      |=> pre_cnt_r == 8'h00)
      else $error("sleep left prescaler count");
   a_status_read: assert property (BUS_RD && CLK_EN && BUS_ADDR == OFS_STATUS
      |=> BUS_RDATA[STATUS_TO_BIT] == $past(TIMEOUT_FLAG) &&
      BUS_RDATA[STATUS_PD_BIT] == $past(POWERDOWN_FLAG))
      else $error("status read does not match flags");
   a_id_write_locked: assert property (BUS_WR && CLK_EN && !PROG_MODE &&
      BUS_ADDR == OFS_ID_FIRST + 14'h0001 |=> $stable(id_mem_r[1]))
      else $error("ID word written outside program mode");

   c_sleep_entry: cover property (sleep_go);
   c_wdt_wake: cover property (wdt_exp && state_r == ST_SLEEP);
   c_irq_vector: cover property (WAKE && WAKE_VECTOR);
   c_wdt_reset: cover property (wdt_exp && state_r == ST_RUN);
   c_ost_wake: cover property (state_r == ST_OST && state_nxt == ST_RESUME);
endmodule

// file: tb/wsw_core_model.sv
// Behavioural model of the core's instruction stream and interrupt view
`timescale 1ns/1ps
module wsw_core_model (
   input wire logic clk,
   output wsw_pkg::wsw_instr_t instr,
   output wsw_pkg::wsw_irq_t irq
);
   import wsw_pkg::*;
   // Quiet core from time zero
   initial begin
      instr = '0;
      irq = '0;
   end
   // One instruction event lasts exactly one cycle
   task automatic exec(input logic clr, input logic slp);
      @(posedge clk);
      instr <= '{watchdog_clear_instr: clr, sleep: slp};
      @(posedge clk);
      instr <= '0;
   endtask
   // Firmware habit: clear the watchdog right before sleeping
   task automatic go_sleep();
      exec(1'b1, 1'b0);
      exec(1'b0, 1'b1);
   endtask
   // Interrupt controller levels change just after an edge
   task automatic set_irq(input logic [IRQ_W-1:0] f, e, s, input logic g);
      @(posedge clk);
      irq <= '{flags: f, enables: e, sleep_capable: s, global_irq_enable: g};
   endtask
endmodule

// file: tb/tb_watchdog_sleep_wake_control.sv
// Self-checking bench for the watchdog and sleep controller
`timescale 1ns/1ps
module tb_watchdog_sleep_wake_control;
   import wsw_pkg::*;
   localparam int TICKS = 4;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [13:0] bus_addr = '0;
   logic [7:0] bus_wdata = '0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [7:0] bus_rdata;
   logic [7:0] config_word = 8'h07;
   logic prog_mode = 1'b0;
   logic master_clear_input_n = 1'b1;
   logic wdt_osc = 1'b0;
   logic dev_reset, core_run, osc_drv_en, io_hold, wake, wake_vector, prog_read_en;
   logic to_flag, pd_flag;
   wsw_instr_t instr;
   wsw_irq_t irq;
   int error_cnt = 0;
   int num_checks = 0;
   // Core clock and a free-running watchdog oscillator, eight clocks a tick
   always #20 sys_clk = ~sys_clk;
   initial begin
      #3;
      forever #160 wdt_osc = ~wdt_osc;
   end
   wsw_core #(.WDT_TICKS(TICKS)) u_wsw_core (.SYS_CLK(sys_clk), .RESETN(resetn),
      .CLK_EN(1'b1), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr),
      .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata), .INSTR(instr), .IRQ(irq),
      .CONFIG_WORD(config_word), .PROG_MODE(prog_mode), .MASTER_CLEAR_INPUT_N(master_clear_input_n),
      .WDT_OSC(wdt_osc), .DEV_RESET(dev_reset), .CORE_RUN(core_run),
      .OSC_DRV_EN(osc_drv_en), .IO_HOLD(io_hold), .WAKE(wake), .WAKE_VECTOR(wake_vector),
      .PROG_READ_EN(prog_read_en), .TIMEOUT_FLAG(to_flag), .POWERDOWN_FLAG(pd_flag));
   wsw_core_model u_wsw_core_model (.clk(sys_clk), .instr(instr), .irq(irq));
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   // Verdict and end of run
   task automatic results();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Synchronous reset, then let the pin synchronisers settle
   task automatic do_reset();
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
   endtask
   // Register bus write and read, one-cycle strobes
   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd_chk(input string nm, input logic [13:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1;
      chk(nm, exp, bus_rdata);
   endtask
   // Count clocks until wake or reset shows, bounded
   task automatic wait_out(input bit on_wake, input int lim, output int n);
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (n < lim && (on_wake ? wake : dev_reset) !== 1'b1);
   endtask
   // Align to a tick, issue clear or sleep, count oscillator ticks to expiry
   task automatic meas(input bit slp, output int ticks, output bit saw_rst);
      logic prev;
      @(posedge wdt_osc);
      repeat (5) @(posedge sys_clk);
      u_wsw_core_model.exec(!slp, slp);
      ticks = 0;
      saw_rst = 0;
      prev = wdt_osc;
      while (ticks < 600 && (slp ? wake : dev_reset) !== 1'b1) begin
         @(posedge sys_clk);
         #1;
         if (wdt_osc && !prev) ticks++;
         prev = wdt_osc;
         if (slp && dev_reset === 1'b1) saw_rst = 1;
      end
   endtask
   // Watchdog process cuts a hang short
   initial begin
      repeat (60000) @(posedge sys_clk);
      error_cnt++;
      results();
   end
   // Main sequence
   initial begin
      int n;
      int i;
      bit r;
      logic g;
      logic [7:0] d;
      logic [7:0] m;
      logic [2:0] ratio [5];
      void'($urandom(32));
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      chk("pd_por", 1, pd_flag);
      rd_chk("status_por", OFS_STATUS, 8'((1 << STATUS_TO_BIT) | (1 << STATUS_PD_BIT)));
      rd_chk("option_rst", OFS_OPTION, OPTION_RESET);
      d = 8'($urandom);
      wr(OFS_OPTION, d);
      rd_chk("option", OFS_OPTION, d);
      wr(OFS_CONFIG, ~config_word);
      rd_chk("config", OFS_CONFIG, config_word);
      rd_chk("unmapped", 14'h0050, 8'h00);
      wr(OFS_ID_FIRST + 14'h1, 8'h05);
      rd_chk("id_locked", OFS_ID_FIRST + 14'h1, 8'h00);
      prog_mode <= 1'b1;
      for (i = 0; i < 4; i++) wr(OFS_ID_FIRST + 14'(i), 8'(d + i));
      for (i = 0; i < 4; i++) rd_chk("id", OFS_ID_FIRST + 14'(i), 8'(d + i));
      // Readout gate over every code-protect setting and mode
      for (i = 0; i < 8; i++) begin
         @(posedge sys_clk);
         config_word <= {2'b00, 2'(i), 4'h7};
         prog_mode <= i[2];
         @(posedge sys_clk);
         #1;
         chk("prog_read_en", i == 7, prog_read_en);
      end
      prog_mode <= 1'b0;
      config_word <= 8'h07;
      // Running expiry for several prescaler settings, boundaries included
      ratio = '{3'd0, 3'd7, 3'($urandom), 3'($urandom), 3'($urandom)};
      for (i = 0; i < 5; i++) begin
         do_reset();
         d = {4'($urandom), i != 4, ratio[i]};
         wr(OFS_OPTION, d);
         meas(1'b0, n, r);
         chk("run_ticks", d[3] ? (TICKS << d[2:0]) : TICKS, n);
         chk("reset_pulse", 1, dev_reset);
         chk("to_expiry", 0, to_flag);
         rd_chk("option_kept", OFS_OPTION, d);
      end
      // Expiry in sleep wakes without reset
      do_reset();
      wr(OFS_OPTION, 8'h00);
      // Global enable set, so a vector after a watchdog wake would show
      u_wsw_core_model.set_irq(8'h00, 8'h00, 8'hff, 1'b1);
      meas(1'b1, n, r);
      chk("sleep_ticks", TICKS, n);
      chk("sleep_no_reset", 0, r);
      chk("wdt_no_vector", 0, wake_vector);
      chk("to_wake", 0, to_flag);
      // Fuse off: no expiry over a long span
      config_word <= 8'h03;
      do_reset();
      wr(OFS_OPTION, 8'h00);
      wait_out(1'b0, 800, n);
      chk("wdt_off", 800, n);
      // Interrupt wake paths with the watchdog off
      i = $urandom % 8;
      g = 1'($urandom);
      m = 8'h01 << i;
      u_wsw_core_model.set_irq(m, m, 8'hff, g);
      u_wsw_core_model.exec(1'b0, 1'b1);
      repeat (3) @(posedge sys_clk);
      #1;
      chk("noop_run", 1, core_run);
      chk("noop_pd", 1, pd_flag);
      u_wsw_core_model.set_irq(8'h00, 8'hff, ~m, g);
      u_wsw_core_model.go_sleep();
      u_wsw_core_model.set_irq(m, 8'hff, ~m, g);
      repeat (8) @(posedge sys_clk);
      u_wsw_core_model.set_irq(m, ~m, 8'hff, g);
      repeat (8) @(posedge sys_clk);
      #1;
      chk("asleep", 0, core_run);
      chk("osc_off", 0, osc_drv_en);
      chk("io_hold", 1, io_hold);
      chk("pd_sleep", 0, pd_flag);
      chk("to_sleep", 1, to_flag);
      u_wsw_core_model.set_irq(m, m, 8'hff, g);
      wait_out(1'b1, 10, n);
      chk("irq_vector", g, wake_vector);
      chk("rc_no_ost", 1, n <= 4);
      // Crystal mode: interrupt right after sleep, start-up wait applies
      config_word <= 8'h00;
      u_wsw_core_model.set_irq(8'h00, m, 8'hff, g);
      u_wsw_core_model.exec(1'b0, 1'b1);
      u_wsw_core_model.set_irq(m, m, 8'hff, g);
      wait_out(1'b1, 1100, n);
      chk("ost_wait", 1, n >= 1024 && n <= 1030);
      chk("pd_late_irq", 0, pd_flag);
      chk("to_late_irq", 1, to_flag);
      rd_chk("status_sleep", OFS_STATUS, 8'(1 << STATUS_TO_BIT));
      // Master clear ends sleep with a reset
      u_wsw_core_model.set_irq(8'h00, 8'h00, 8'hff, g);
      u_wsw_core_model.exec(1'b0, 1'b1);
      master_clear_input_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
      chk("master_clear_input_reset", 1, dev_reset);
      chk("master_clear_input_run", 1, core_run);
      master_clear_input_n <= 1'b1;
      do_reset();
      results();
   end
endmodule
